// file: src/uefc_cfg.svh
// Purpose: Offsets, field positions, reset values for the enhanced flow block
// Assumes: AHB-Lite word registers, byte address = offset
// Notes:   Definitions only
`ifndef UEFC_CFG_SVH
`define UEFC_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UEFC_OFF_IER       6'h00
`define UEFC_OFF_ISR       6'h04
`define UEFC_OFF_MCR       6'h08
`define UEFC_OFF_MSR       6'h0C
`define UEFC_OFF_EFR       6'h10
`define UEFC_OFF_RES1      6'h14
`define UEFC_OFF_RES2      6'h18
`define UEFC_OFF_PAUSE1    6'h1C
`define UEFC_OFF_PAUSE2    6'h20
`define UEFC_OFF_SPR       6'h24
`define UEFC_OFF_FCR       6'h28
`define UEFC_OFF_LCR       6'h2C
`define UEFC_OFF_LSR       6'h30
`define UEFC_OFF_RXDATA    6'h34
`define UEFC_OFF_CHSEL     6'h38

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UEFC_RST_ZERO      8'h00
`define UEFC_RST_ISR       8'h01
`define UEFC_RST_LSR       8'h60
`define UEFC_RST_SPR       8'hFF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UEFC_EFR_ENH       4
`define UEFC_EFR_SPEC      5
`define UEFC_EFR_ARTS      6
`define UEFC_EFR_ACTS      7
`define UEFC_IER_SPEC      5
`define UEFC_ISR_SPEC      4
`define UEFC_MCR_RTS       1
`define UEFC_MCR_OP2       3
`define UEFC_MCR_DTR       0
`define UEFC_IER_ENH_MASK  8'hF0
`define UEFC_ISR_ENH_MASK  8'h30
`define UEFC_MCR_ENH_MASK  8'hE0
`define UEFC_RX_CMP_PAIR1  2'b10
`define UEFC_RX_CMP_PAIR2  2'b01
`define UEFC_RX_CMP_NONE   2'b00
`define UEFC_RX_CMP_BOTH   2'b11

`endif

// file: src/uefc_pkg.sv
// Purpose: Types for the enhanced flow block
// Assumes: Nothing
// Notes:   Channel count fixed at two
package uefc_pkg;
    typedef logic [7:0] uefc_byte_t;
    typedef enum logic [2:0] {
        UEFC_AP_IDLE  = 3'b001,
        UEFC_AP_WRITE = 3'b010,
        UEFC_AP_READ  = 3'b100
    } uefc_phase_t;
endpackage

// file: src/uefc_top.sv
// Purpose: Enhanced feature latch, special character, auto RTS/CTS, flow chars
// Assumes: AHB-Lite slave, zero wait states, two channels selected by CHSEL
// Notes:   Receive characters and FIFO levels arrive from the surrounding UART
//
// Notes on behaviour
// - Enhanced interrupt enable, status, modem control bits writable only while enabled
// - Reset clears those enhanced bits and enhanced enable
// - Special detect compares each received char with pause char 2, sets status bit 4
// - Special detect compares the whole received character with pause char 2, not bitwise
// - Compare pair 1 with special detect: both work normally
// - Compare pair 2: matching pause 2 dropped, pause and special interrupts
// - Special interrupt clears when next character is received
// - Auto RTS: interrupt at trigger level, RTS high at upper level
// - Auto RTS: RTS low again below lower level
// - Without hardware flow control RTS follows modem control bit
// - Auto CTS stops transmit while CTS high, resets disabled
// - Four readable writable 8-bit resume and pause character registers
// - Per channel reset values of all listed registers
// - Reset clears modem change flags, levels show inverted inputs
// - Reset drives TX, general output, RTS, DTR, receive ready high, transmit ready low, INT off
// - Power save isolates bus and modem inputs from internal logic
// - Low two enhanced bits select receive comparison mode
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "uefc_cfg.svh"

module uefc_top
    import uefc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Power save
    input  wire logic        power_save,
    // Receive path, per channel
    input  wire logic [1:0]  rx_char_valid,
    input  wire logic [15:0] rx_char,
    input  wire logic [1:0]  rx_at_trigger,
    input  wire logic [1:0]  rx_at_upper,
    input  wire logic [1:0]  rx_below_lower,
    output logic      [1:0]  rx_push,
    output logic      [15:0] rx_push_data,
    output logic      [1:0]  pause_rx_event,
    output logic      [1:0]  rx_trigger_irq,
    output logic      [1:0]  special_irq,
    // Transmit gate and pins, per channel
    input  wire logic [1:0]  tx_serial_in,
    input  wire logic [1:0]  tx_ready_in,
    input  wire logic [1:0]  rx_ready_in,
    output logic      [1:0]  tx_enable,
    output logic      [1:0]  tx_serial,
    output logic      [1:0]  transmit_ready_n,
    output logic      [1:0]  receive_ready_n,
    // Modem pins, per channel: CTS, DSR, RI, CD active low inputs
    input  wire logic [7:0]  modem_in_n,
    output logic      [1:0]  rts_n,
    output logic      [1:0]  dtr_n,
    output logic      [1:0]  general_output_n,
    output logic      [1:0]  int_out,
    output logic      [1:0]  int_oe
);

    // ----------------------------------------------------------------
    // Input isolation in power save
    // ----------------------------------------------------------------
    logic        bus_sel;
    logic [7:0]  modem_iso;
    logic [7:0]  modem_hold;

    assign bus_sel = hsel & ~power_save;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            modem_hold <= 8'hFF;
        end else if (!power_save) begin
            modem_hold <= modem_in_n;
        end
    end

    assign modem_iso = power_save ? modem_hold : modem_in_n;

    // ----------------------------------------------------------------
    // AHB-Lite address phase capture
    // ----------------------------------------------------------------
    uefc_phase_t phase;
    logic [5:0]  ap_addr;
    logic        ap_ok;
    logic        chan;

    assign ap_ok = bus_sel & hready & htrans[1];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase   <= UEFC_AP_IDLE;
            ap_addr <= 6'h00;
        end else if (hready) begin
            phase   <= !ap_ok ? UEFC_AP_IDLE : (hwrite ? UEFC_AP_WRITE : UEFC_AP_READ);
            ap_addr <= haddr[5:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic        wr;
    uefc_byte_t  wd;
    assign wr = (phase == UEFC_AP_WRITE);
    assign wd = hwdata[7:0];

    // Channel select register chooses which channel the map addresses
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chan <= 1'b0;
        end else if (wr && ap_addr == `UEFC_OFF_CHSEL) begin
            chan <= wd[0];
        end
    end

    // ----------------------------------------------------------------
    // Per channel state
    // ----------------------------------------------------------------
    uefc_byte_t interrupt_enable_reg [2];
    uefc_byte_t interrupt_status_reg [2];
    uefc_byte_t modem_control_reg [2];
    uefc_byte_t enhanced_feature_ctrl [2];
    uefc_byte_t res1 [2];
    uefc_byte_t res2 [2];
    uefc_byte_t pause1 [2];
    uefc_byte_t pause2 [2];
    uefc_byte_t scratch_reg [2];
    uefc_byte_t fifo_control_reg [2];
    uefc_byte_t line_control_reg [2];
    uefc_byte_t line_status_reg [2];
    uefc_byte_t rxd [2];
    logic [3:0] msr_delta [2];
    logic [3:0] modem_prev [2];
    logic [1:0] rts_auto_high;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic       wsel;
        logic       enh;
        uefc_byte_t ch;
        logic       match;
        logic       drop;
        logic [3:0] lvl;

        assign wsel  = wr && (chan == c[0]);
        assign enh   = enhanced_feature_ctrl[c][`UEFC_EFR_ENH];
        assign ch    = rx_char[c*8 +: 8];
        assign match = enhanced_feature_ctrl[c][`UEFC_EFR_SPEC] && rx_char_valid[c]
                       && (ch == pause2[c]);
        assign drop  = match && (enhanced_feature_ctrl[c][1:0] == `UEFC_RX_CMP_PAIR2);
        assign lvl   = ~modem_iso[c*4 +: 4];

        // Plain byte registers
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                enhanced_feature_ctrl[c]    <= `UEFC_RST_ZERO;
                res1[c]   <= `UEFC_RST_ZERO;
                res2[c]   <= `UEFC_RST_ZERO;
                pause1[c] <= `UEFC_RST_ZERO;
                pause2[c] <= `UEFC_RST_ZERO;
                scratch_reg[c]    <= `UEFC_RST_SPR;
                fifo_control_reg[c]    <= `UEFC_RST_ZERO;
                line_control_reg[c]    <= `UEFC_RST_ZERO;
                line_status_reg[c]    <= `UEFC_RST_LSR;
            end else if (wsel) begin
                unique case (ap_addr)
                    `UEFC_OFF_EFR:    enhanced_feature_ctrl[c]    <= wd;
                    `UEFC_OFF_RES1:   res1[c]   <= wd;
                    `UEFC_OFF_RES2:   res2[c]   <= wd;
                    `UEFC_OFF_PAUSE1: pause1[c] <= wd;
                    `UEFC_OFF_PAUSE2: pause2[c] <= wd;
                    `UEFC_OFF_SPR:    scratch_reg[c]    <= wd;
                    `UEFC_OFF_FCR:    fifo_control_reg[c]    <= wd;
                    `UEFC_OFF_LCR:    line_control_reg[c]    <= wd;
                    default: ;
                endcase
            end
        end

        // Interrupt enable and modem control with enhanced latch
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                interrupt_enable_reg[c] <= `UEFC_RST_ZERO;
                modem_control_reg[c] <= `UEFC_RST_ZERO;
            end else if (wsel && ap_addr == `UEFC_OFF_IER) begin
                interrupt_enable_reg[c] <= enh ? wd : ((interrupt_enable_reg[c] & `UEFC_IER_ENH_MASK)
                          | (wd & ~`UEFC_IER_ENH_MASK));
            end else if (wsel && ap_addr == `UEFC_OFF_MCR) begin
                modem_control_reg[c] <= enh ? wd : ((modem_control_reg[c] & `UEFC_MCR_ENH_MASK)
                          | (wd & ~`UEFC_MCR_ENH_MASK));
            end
        end

        // Status: special flag set wins over next-char clear and write
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                interrupt_status_reg[c] <= `UEFC_RST_ISR;
            end else begin
                if (wsel && ap_addr == `UEFC_OFF_ISR && enh) begin
                    interrupt_status_reg[c][5:4] <= wd[5:4];
                end else if (rx_char_valid[c]) begin
                    interrupt_status_reg[c][`UEFC_ISR_SPEC] <= 1'b0;
                end
                if (match) begin
                    interrupt_status_reg[c][`UEFC_ISR_SPEC] <= 1'b1;
                end
            end
        end

        // Receive FIFO feed and pause event
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                rx_push[c]             <= 1'b0;
                rx_push_data[c*8 +: 8] <= 8'h00;
                pause_rx_event[c]      <= 1'b0;
                special_irq[c]         <= 1'b0;
                rxd[c]                 <= 8'h00;
            end else begin
                rx_push[c]        <= rx_char_valid[c] && !drop;
                pause_rx_event[c] <= drop;
                if (rx_char_valid[c]) begin
                    rx_push_data[c*8 +: 8] <= ch;
                    rxd[c]                 <= ch;
                end
                special_irq[c] <= (match || (interrupt_status_reg[c][`UEFC_ISR_SPEC] && !rx_char_valid[c]))
                                  && interrupt_enable_reg[c][`UEFC_IER_SPEC];
            end
        end

        // Modem change flags
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                msr_delta[c]  <= 4'h0;
                modem_prev[c] <= 4'h0;
            end else begin
                modem_prev[c] <= lvl;
                if (wsel && ap_addr == `UEFC_OFF_MSR) begin
                    msr_delta[c] <= lvl ^ modem_prev[c];
                end else begin
                    msr_delta[c] <= msr_delta[c] | (lvl ^ modem_prev[c]);
                end
            end
        end

        // Auto RTS hysteresis
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                rts_auto_high[c]  <= 1'b0;
                rx_trigger_irq[c] <= 1'b0;
            end else begin
                rx_trigger_irq[c] <= enhanced_feature_ctrl[c][`UEFC_EFR_ARTS] && rx_at_trigger[c];
                if (!enhanced_feature_ctrl[c][`UEFC_EFR_ARTS] || rx_below_lower[c]) begin
                    rts_auto_high[c] <= 1'b0;
                end else if (rx_at_upper[c]) begin
                    rts_auto_high[c] <= 1'b1;
                end
            end
        end

        // Pins
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                rts_n[c]            <= 1'b1;
                dtr_n[c]            <= 1'b1;
                general_output_n[c] <= 1'b1;
                tx_serial[c]        <= 1'b1;
                receive_ready_n[c]  <= 1'b1;
                transmit_ready_n[c] <= 1'b0;
                tx_enable[c]        <= 1'b0;
                int_out[c]          <= 1'b0;
                int_oe[c]           <= 1'b0;
            end else begin
                // Auto RTS only acts once software asserted RTS
                rts_n[c] <= ~modem_control_reg[c][`UEFC_MCR_RTS]
                            | rts_auto_high[c];
                dtr_n[c]            <= ~modem_control_reg[c][`UEFC_MCR_DTR];
                general_output_n[c] <= ~modem_control_reg[c][`UEFC_MCR_OP2];
                tx_serial[c]        <= tx_serial_in[c];
                receive_ready_n[c]  <= ~rx_ready_in[c];
                transmit_ready_n[c] <= ~tx_ready_in[c];
                tx_enable[c] <= !(enhanced_feature_ctrl[c][`UEFC_EFR_ACTS] && modem_iso[c*4]);
                int_out[c]   <= ~interrupt_status_reg[c][0];
                int_oe[c]    <= modem_control_reg[c][`UEFC_MCR_OP2];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    uefc_byte_t rsel;
    always_comb begin
        unique case (ap_addr)
            `UEFC_OFF_IER:    rsel = interrupt_enable_reg[chan];
            `UEFC_OFF_ISR:    rsel = interrupt_status_reg[chan];
            `UEFC_OFF_MCR:    rsel = modem_control_reg[chan];
            `UEFC_OFF_MSR:    rsel = {~modem_iso[chan*4 +: 4], msr_delta[chan]};
            `UEFC_OFF_EFR:    rsel = enhanced_feature_ctrl[chan];
            `UEFC_OFF_RES1:   rsel = res1[chan];
            `UEFC_OFF_RES2:   rsel = res2[chan];
            `UEFC_OFF_PAUSE1: rsel = pause1[chan];
            `UEFC_OFF_PAUSE2: rsel = pause2[chan];
            `UEFC_OFF_SPR:    rsel = scratch_reg[chan];
            `UEFC_OFF_FCR:    rsel = fifo_control_reg[chan];
            `UEFC_OFF_LCR:    rsel = line_control_reg[chan];
            `UEFC_OFF_LSR:    rsel = line_status_reg[chan];
            `UEFC_OFF_RXDATA: rsel = rxd[chan];
            `UEFC_OFF_CHSEL:  rsel = {7'h00, chan};
            default:          rsel = 8'h00;
        endcase
    end

    assign hrdata = (phase == UEFC_AP_READ) ? {24'h000000, rsel} : 32'h00000000;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_enh_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!enhanced_feature_ctrl[0][`UEFC_EFR_ENH] && !(wr && !chan && ap_addr == `UEFC_OFF_EFR))
        |=> interrupt_enable_reg[0][7:4] == $past(interrupt_enable_reg[0][7:4]))
        else $error("enhanced ier bits changed while locked");
    chk_spec_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enhanced_feature_ctrl[0][`UEFC_EFR_SPEC] && rx_char_valid[0] && rx_char[7:0] == pause2[0])
        |=> interrupt_status_reg[0][`UEFC_ISR_SPEC])
        else $error("special flag not set on match");
    chk_spec_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        (rx_char_valid[0] && !g_ch[0].match && !(wr && !chan && ap_addr == `UEFC_OFF_ISR))
        |=> !interrupt_status_reg[0][`UEFC_ISR_SPEC])
        else $error("special flag not cleared by next char");
    chk_pair2_drop: assert property (@(posedge sys_clk) disable iff (!rstn)
        g_ch[0].drop |=> !rx_push[0] && pause_rx_event[0])
        else $error("pause 2 entered fifo");
    chk_pair1_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
        (g_ch[0].match && enhanced_feature_ctrl[0][1:0] == `UEFC_RX_CMP_PAIR1) |=> rx_push[0])
        else $error("pair 1 match not stored");
    chk_rts_upper: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enhanced_feature_ctrl[0][`UEFC_EFR_ARTS] && rx_at_upper[0] && !rx_below_lower[0]
         && !(wsel_any())) |=> ##1 rts_n[0])
        else $error("rts not raised at upper level");
    chk_rts_lower: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enhanced_feature_ctrl[0][`UEFC_EFR_ARTS] && rx_below_lower[0]) |=> ##1 rts_n[0] == ~$past(modem_control_reg[0][`UEFC_MCR_RTS]))
        else $error("rts not lowered below lower level");
    chk_rts_plain: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!enhanced_feature_ctrl[0][`UEFC_EFR_ARTS] && !rts_auto_high[0]) |=> rts_n[0] == ~$past(modem_control_reg[0][1]))
        else $error("rts not following modem control");
    chk_cts_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
        (enhanced_feature_ctrl[0][`UEFC_EFR_ACTS] && modem_iso[0]) |=> !tx_enable[0])
        else $error("transmit not stopped by cts");
    cov_spec: cover property (@(posedge sys_clk) disable iff (!rstn) g_ch[0].match);
    cov_drop: cover property (@(posedge sys_clk) disable iff (!rstn) g_ch[0].drop);
    cov_cts:  cover property (@(posedge sys_clk) disable iff (!rstn) !tx_enable[0]);
    cov_rts:  cover property (@(posedge sys_clk) disable iff (!rstn) rts_auto_high[0]);

    function automatic logic wsel_any();
        return wr;
    endfunction

endmodule
`default_nettype wire

// file: verification/uart_enhanced_feature_flow_ctrl_tb_top.sv
// Purpose: Self-checking bench for the enhanced flow block
// Assumes: Zero-wait AHB-Lite slave, channel 0 unless selected
// Notes:   Read data and pushed characters checked from queues
`timescale 1ns/1ps
`default_nettype none
`include "uefc_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end

module uart_enhanced_feature_flow_ctrl_tb_top;
    import uefc_pkg::*;
    logic        sys_clk, rstn, hsel, hwrite, power_save, rd_on, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rnd_state;
    logic [2:0]  hsize;
    logic [1:0]  htrans, rx_at_trigger, rx_at_upper, rx_below_lower, rx_char_valid;
    logic [1:0]  rx_push, pause_rx_event, rx_trigger_irq, special_irq, tx_enable;
    logic [1:0]  tx_serial, transmit_ready_n, receive_ready_n, int_out, int_oe;
    logic [1:0]  rts_n, dtr_n, general_output_n;
    logic [15:0] rx_char, rx_push_data, ex;
    logic [7:0]  modem_in_n, pe;
    logic [15:0] exp_q[$];
    logic [7:0]  push_q[$];
    int          bad_count, n_tests;
    localparam logic [15:0] RST_TAB [12] = '{16'h0000, 16'h0401, 16'h0800, 16'h1000,
        16'h1400, 16'h1800, 16'h1C00, 16'h2000, 16'h24FF, 16'h2800, 16'h2C00, 16'h3060};

    uefc_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .power_save(power_save), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .rx_at_trigger(rx_at_trigger), .rx_at_upper(rx_at_upper),
        .rx_below_lower(rx_below_lower), .rx_push(rx_push), .rx_push_data(rx_push_data),
        .pause_rx_event(pause_rx_event), .rx_trigger_irq(rx_trigger_irq),
        .special_irq(special_irq), .tx_serial_in(2'b11), .tx_ready_in(2'b11),
        .rx_ready_in(2'b11), .tx_enable(tx_enable), .tx_serial(tx_serial),
        .transmit_ready_n(transmit_ready_n), .receive_ready_n(receive_ready_n),
        .modem_in_n(modem_in_n), .rts_n(rts_n), .dtr_n(dtr_n),
        .general_output_n(general_output_n), .int_out(int_out), .int_oe(int_oe));

    uefc_remote_model i_rem (.sys_clk(sys_clk), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .modem_in_n(modem_in_n));

    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                       input logic [7:0] m, input logic [7:0] e);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {26'h0, a};
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        rd_on  <= ~w;
        if (!w) exp_q.push_back({m, e});
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd_on  <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 8'h00, 8'h00);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
        bus(1'b0, a, 8'h00, m, e);
    endtask

    task automatic rx(input logic [7:0] c, input logic keep);
        if (keep) push_q.push_back(c);
        i_rem.send(0, c);
    endtask

    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic close_out;
        $display("Checks %0d, errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Result watcher
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rd_on) begin
            ex = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFFXX;
            `CHK(hrdata[7:0] & ex[15:8], ex[7:0])
        end
        if (rx_push[0]) begin
            pe = (push_q.size() > 0) ? push_q.pop_front() : 8'hXX;
            `CHK(rx_push_data[7:0], pe)
        end
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        close_out;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rstn, hsel, hwrite, power_save, rd_on} = '0;
        {htrans, rx_at_trigger, rx_at_upper, rx_below_lower} = '0;
        {haddr, hwdata} = '0;
        hsize = 3'h2;
        rnd_state = 32'h9BFA6E2C;
        bad_count = 0;
        n_tests = 0;
        repeat (8) @(posedge sys_clk);
        #1;
        `CHK({rts_n, dtr_n, general_output_n, tx_serial, receive_ready_n}, 10'h3FF)
        `CHK({transmit_ready_n, int_oe}, 4'h0)
        @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (RST_TAB[i]) rd(RST_TAB[i][13:8], 8'hFF, RST_TAB[i][7:0]);
        rd(`UEFC_OFF_MSR, 8'hFF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rnd_state = xs(rnd_state);
            wr(6'h14 + 6'(4 * i), rnd_state[7:0]);
            rd(6'h14 + 6'(4 * i), 8'hFF, rnd_state[7:0]);
        end
        wr(`UEFC_OFF_IER, 8'hFF);
        wr(`UEFC_OFF_MCR, 8'hE2);
        rd(`UEFC_OFF_IER, 8'hFF, 8'h0F);
        rd(`UEFC_OFF_MCR, 8'hFF, 8'h02);
        settle;
        `CHK(rts_n[0], 1'b0)
        wr(`UEFC_OFF_EFR, 8'h10);
        wr(`UEFC_OFF_IER, 8'hFF);
        wr(`UEFC_OFF_MCR, 8'hE0);
        rd(`UEFC_OFF_IER, 8'hFF, 8'hFF);
        settle;
        `CHK(rts_n[0], 1'b1)
        wr(`UEFC_OFF_EFR, 8'h00);
        wr(`UEFC_OFF_IER, 8'h00);
        wr(`UEFC_OFF_MCR, 8'h00);
        rd(`UEFC_OFF_IER, 8'hFF, 8'hF0);
        rd(`UEFC_OFF_MCR, 8'hFF, 8'hE0);
        wr(`UEFC_OFF_EFR, 8'h10);
        wr(`UEFC_OFF_IER, 8'h20);
        wr(`UEFC_OFF_MCR, 8'h0B);
        wr(`UEFC_OFF_PAUSE2, 8'h83);
        wr(`UEFC_OFF_EFR, 8'h30);
        rx(8'hC1, 1'b1);
        rd(`UEFC_OFF_ISR, 8'h10, 8'h00);
        rx(8'h83, 1'b1);
        rd(`UEFC_OFF_ISR, 8'h10, 8'h10);
        `CHK(special_irq[0], 1'b1)
        rx(8'h55, 1'b1);
        settle;
        `CHK(special_irq[0], 1'b0)
        `CHK({tx_serial, receive_ready_n, transmit_ready_n, dtr_n[0], general_output_n[0], int_oe[0], int_out[0]}, 10'h302)
        rd(`UEFC_OFF_ISR, 8'h10, 8'h00);
        wr(`UEFC_OFF_EFR, 8'h10);
        wr(`UEFC_OFF_EFR, 8'h31);
        rx(8'h83, 1'b0);
        #1;
        `CHK(pause_rx_event[0], 1'b1)
        settle;
        `CHK(special_irq[0], 1'b1)
        wr(`UEFC_OFF_EFR, 8'h10);
        wr(`UEFC_OFF_EFR, 8'h32);
        rx(8'h83, 1'b1);
        rd(`UEFC_OFF_ISR, 8'h10, 8'h10);
        wr(`UEFC_OFF_EFR, 8'h10);
        wr(`UEFC_OFF_EFR, 8'h50);
        @(posedge sys_clk);
        rx_at_trigger <= 2'b01;
        rx_at_upper   <= 2'b01;
        settle;
        `CHK(rx_trigger_irq[0], 1'b1)
        `CHK(rts_n[0], 1'b1)
        @(posedge sys_clk);
        rx_at_upper    <= 2'b00;
        rx_below_lower <= 2'b01;
        settle;
        `CHK(rts_n[0], 1'b0)
        @(posedge sys_clk);
        rx_below_lower <= 2'b00;
        i_rem.set_cts_n(0, 1'b1);
        settle;
        `CHK(tx_enable[0], 1'b1)
        wr(`UEFC_OFF_EFR, 8'h90);
        settle;
        `CHK(tx_enable[0], 1'b0)
        i_rem.set_cts_n(0, 1'b0);
        settle;
        `CHK(tx_enable[0], 1'b1)
        rd(`UEFC_OFF_MSR, 8'hFF, 8'h11);
        wr(`UEFC_OFF_CHSEL, 8'h01);
        rd(`UEFC_OFF_EFR, 8'hFF, 8'h00);
        rd(`UEFC_OFF_IER, 8'hFF, 8'h00);
        wr(`UEFC_OFF_CHSEL, 8'h00);
        rd(`UEFC_OFF_EFR, 8'hFF, 8'h90);
        @(posedge sys_clk);
        power_save <= 1'b1;
        wr(`UEFC_OFF_SPR, 8'h00);
        i_rem.set_cts_n(0, 1'b1);
        settle;
        `CHK(tx_enable[0], 1'b1)
        @(posedge sys_clk);
        power_save <= 1'b0;
        rd(`UEFC_OFF_SPR, 8'hFF, 8'hFF);
        rd(6'h3C, 8'hFF, 8'h00);
        `CHK(hresp, 1'b0)
        close_out;
    end
endmodule

`undef CHK
`default_nettype wire

// file: verification/uefc_remote_model.sv
// Purpose: Remote serial device feeding received characters and modem levels
// Assumes: One character at a time, one channel per call
// Notes:   Character lines show an inverted value between characters
`timescale 1ns/1ps
`default_nettype none

module uefc_remote_model (
    // Clock
    input  wire logic        sys_clk,
    // Link side
    output logic      [1:0]  rx_char_valid,
    output logic      [15:0] rx_char,
    output logic      [7:0]  modem_in_n
);
    initial begin
        rx_char_valid = 2'h0;
        rx_char       = 16'hA5A5;
        modem_in_n    = 8'hFF;
    end

    // One-cycle character strobe, line inverted afterwards
    task automatic send(input int ch, input logic [7:0] c);
        @(posedge sys_clk);
        rx_char_valid[ch]  <= 1'b1;
        rx_char[8*ch +: 8] <= c;
        @(posedge sys_clk);
        rx_char_valid[ch]  <= 1'b0;
        rx_char[8*ch +: 8] <= ~c;
    endtask

    task automatic set_cts_n(input int ch, input logic lvl);
        @(posedge sys_clk);
        modem_in_n[4*ch] <= lvl;
    endtask
endmodule

`default_nettype wire
